// ===== test/xos_startup_checker.sv
/* Port checker for the start-up controller.
   Assumes fuses stay stable from reset release until internal reset falls. */
`timescale 1ns/100ps
// ******
// Checks
// ******
module xos_startup_checker
  import xos_pkg::*;
(
  input wire logic sys_clk_i, // Clock.
  input wire logic sys_rst_i, // Reset.
  input wire logic [3:0] clock_source_select_fuses_i, // Select fuses.
  input wire logic [1:0] startup_time_fuses_i, // Start-up fuses.
  input wire logic divide_by_eight_fuse_i, // Divider fuse.
  input wire logic wdt_tick_i, // Tick.
  input wire logic sleep_req_i, // Sleep.
  input wire logic internal_reset_o, // Internal reset.
  input wire logic [1:0] freq_range_o, // Range.
  input wire logic range_valid_o, // Valid.
  input wire logic sys_clk_en_o, // Enable.
  input wire logic div8_active_o // Divider on.
);
  int hi_q, hi_d, lo_q, lo_d;
  logic [3:0] c;
  logic [1:0] s;
  assign c = clock_source_select_fuses_i;
  assign s = startup_time_fuses_i;
  always_comb begin
    hi_d = internal_reset_o ? hi_q + 1 : hi_q;
    lo_d = sys_clk_en_o ? 0 : lo_q + 1;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hi_q <= 0;
      lo_q <= 0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rel;
    $fell(internal_reset_o);
  endsequence
  a_range_map: assert property (s_rel |-> freq_range_o == c[2:1] && range_valid_o == c[3])
    else $error("range wrong");
  a_div8_map: assert property (s_rel |-> div8_active_o == (divide_by_eight_fuse_i == XOS_FUSE_PROGRAMMED))
    else $error("divider wrong");
  a_div8_gap: assert property (div8_active_o && sys_clk_en_o |=> (!sys_clk_en_o) [*7])
    else $error("divided gap wrong");
  a_hold_clk: assert property (internal_reset_o |-> !sys_clk_en_o)
    else $error("clock during reset");
  a_stay_low: assert property (!internal_reset_o |=> !internal_reset_o)
    else $error("reset came back");
  a_min_258: assert property (s_rel |-> hi_q >= 277)
    else $error("release too early");
  a_min_1k: assert property (s_rel ##0 (s[1] || c[0]) |-> hi_q >= 1043)
    else $error("1K release too early");
  a_min_16k: assert property (s_rel ##0 (c[0] && s != 2'h0) |-> hi_q >= 16403)
    else $error("16K release too early");
  a_tout_long: assert property (s_rel ##0 (!c[0] && s == 2'h1 || c[0] && s == 2'h0 || c[0] && s == 2'h3)
    |-> hi_q >= 8597)
    else $error("long time-out skipped");
  a_wake_gap: assert property ($rose(sys_clk_en_o) && lo_q > 8 |-> lo_q >= 258)
    else $error("wake too short");
  a_fuse_hold: assert property (!internal_reset_o |-> $stable({freq_range_o, range_valid_o, div8_active_o}))
    else $error("fuse image moved");
endmodule

// ===== test/xos_startup_ctrl_tb.sv
/* Testbench for the start-up controller: five fuse settings, each run
   from reset, divider check, fuse upset and a sleep wake.
   Assumes the watchdog model ticks about every four clocks. */
`timescale 1ns/100ps
// *****
// Bench
// *****
module xos_startup_ctrl_tb;
  import xos_pkg::*;
  typedef struct packed {logic [3:0] f; int lo; int hi;} xos_note_t;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, sleep_req_i = 1'b0, divide_by_eight_fuse_i = 1'b1;
  logic [3:0] clock_source_select_fuses_i = 4'hf;
  logic [1:0] startup_time_fuses_i = 2'h3;
  logic wdt_tick_i, internal_reset_o, range_valid_o, sys_clk_en_o, div8_active_o, ir_q = 1'b1;
  logic [1:0] freq_range_o;
  int bad_count = 0, total_checks = 0, seed = 57219, cyc = 0, t0 = 0, n, i;
  xos_note_t q[$], nt;
  // Resonator settings only: lowest range and 258-cycle entries suit it.
  logic [6:0] cfg[5] = '{7'h65, 7'h40, 7'h7b, 7'h59, 7'h57};
  int su[5] = '{1024, 258, 16384, 1024, 1024};
  int ed[5] = '{0, 512, 0, 8320, 512};
  always #25 sys_clk_i = ~sys_clk_i;
  xos_wdt_model xos_wdt_model_inst (.tick_o(wdt_tick_i));
  xos_startup_ctrl xos_startup_ctrl_inst (.sys_clk_i, .sys_rst_i, .clock_source_select_fuses_i,
    .startup_time_fuses_i, .divide_by_eight_fuse_i, .wdt_tick_i, .sleep_req_i, .internal_reset_o,
    .freq_range_o, .range_valid_o, .sys_clk_en_o, .div8_active_o);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    ir_q <= internal_reset_o;
    if (ir_q === 1'b1 && internal_reset_o === 1'b0 && q.size() > 0) begin
      nt = q.pop_front();
      check({range_valid_o, freq_range_o, div8_active_o}, nt.f);
      check(16'(cyc - t0 >= nt.lo && cyc - t0 <= nt.hi), 16'h1);
    end
    if (cyc == 99000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    for (i = 0; i < 5; i++) begin
      sys_rst_i <= 1'b1;
      @(posedge sys_clk_i);
      {clock_source_select_fuses_i, startup_time_fuses_i, divide_by_eight_fuse_i} <= cfg[i];
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t0 = cyc;
      q.push_back({cfg[i][6:4], ~cfg[i][0], su[i] + 19 + ed[i] * 4, su[i] + 43 + ed[i] * 5});
      n = 0;
      while (internal_reset_o !== 1'b0 && n < 50000) begin
        @(posedge sys_clk_i);
        n++;
      end
      repeat (2) @(posedge sys_clk_i);
      {clock_source_select_fuses_i, startup_time_fuses_i, divide_by_eight_fuse_i} <= 7'($random(seed));
      repeat (6) @(posedge sys_clk_i);
      check({range_valid_o, freq_range_o, div8_active_o}, {cfg[i][6:4], ~cfg[i][0]});
      n = 0;
      repeat (64) begin
        @(posedge sys_clk_i);
        n += sys_clk_en_o;
      end
      check(16'(n), cfg[i][0] ? 16'h40 : 16'h8);
      sleep_req_i <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      sleep_req_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      n = 4;
      while (sys_clk_en_o !== 1'b1 && n < 20000) begin
        @(posedge sys_clk_i);
        n++;
      end
      check(16'(n >= su[i] && n <= su[i] + 20), 16'h1);
      $display("test %0d done", i);
    end
    results();
  end
endmodule
bind xos_startup_ctrl xos_startup_checker xos_startup_checker_inst (.sys_clk_i, .sys_rst_i,
  .clock_source_select_fuses_i, .startup_time_fuses_i, .divide_by_eight_fuse_i, .wdt_tick_i, .sleep_req_i,
  .internal_reset_o, .freq_range_o, .range_valid_o, .sys_clk_en_o, .div8_active_o);

// ===== test/xos_wdt_model.sv
/* Watchdog oscillator model standing beside the resonator.
   Assumes the block synchronises the tick itself. */
`timescale 1ns/100ps
// ****
// Tick
// ****
module xos_wdt_model (
  output logic tick_o // Free-running watchdog level.
);
  // Runs faster than real so the long time-out fits the run.
  initial tick_o = 1'b0;
  always #105 tick_o = ~tick_o;
endmodule

// ===== verilog/xos_pkg.sv
/*
 * Package for the low power crystal oscillator start-up and clock select block.
 * Holds fuse codes, start-up cycle counts, time-out constants and the carrier structs.
 * Assumes a 20 MHz oscillator clock and a watchdog oscillator tick that arrives as a pin.
 */
// Behaviour
// [RULE_01] Upper three clock-select fuse bits pick the frequency range mode 100..111.
// [RULE_02] Low select 0 with start-up fuses 00/01: 258 cycles, reset adds 19 plus 4/65 ms.
// [RULE_03] Low 0 with 10/11, or low 1 with 00: 1K cycles; reset 19, +4 ms, +65 ms.
// [RULE_04] Low 1 with 01/10/11: 16K cycles; reset adds 19, 19+4 ms, 19+65 ms.
// [RULE_05] Programmed divide-by-eight fuse divides the oscillator by 8 for the system clock.
// [RULE_06] Configurer avoids the lowest range with a crystal; resonators only.
// [RULE_07] Configurer uses 258-cycle settings only slow and unstable-tolerant, never with crystals.
// [RULE_08] Internal reset is held while a ripple counter counts oscillator cycles to the target.
// [RULE_09] The millisecond delay is timed in watchdog oscillator cycles chosen by the fuses.
// [RULE_10] A fuse bit of one is unprogrammed, zero is programmed.
// [RULE_11] All fuse values are sampled at reset and held constant while running.
package xos_pkg;

  localparam logic [2:0] XOS_RANGE_0P4 = 3'h4;
  localparam logic [2:0] XOS_RANGE_0P9 = 3'h5;
  localparam logic [2:0] XOS_RANGE_3P0 = 3'h6;
  localparam logic [2:0] XOS_RANGE_8P0 = 3'h7;

  localparam logic [0:0] XOS_FUSE_PROGRAMMED = 1'h0;

  localparam int XOS_CNT_W = 15;
  localparam logic [14:0] XOS_SU_258 = 15'h0102;
  localparam logic [14:0] XOS_SU_1K = 15'h0400;
  localparam logic [14:0] XOS_SU_16K = 15'h4000;
  localparam logic [14:0] XOS_RST_EXTRA = 15'h0013;

  // Watchdog oscillator nominal rate and the two time-out lengths.
  localparam int XOS_WDT_HZ = 128000;
  localparam int XOS_TOUT_SHORT_MS = 4;
  localparam int XOS_TOUT_LONG_MS = 65;
  localparam int XOS_WDT_W = 14;
  localparam logic [13:0] XOS_WDT_SHORT = 14'(XOS_WDT_HZ * XOS_TOUT_SHORT_MS / 1000);
  localparam logic [13:0] XOS_WDT_LONG = 14'(XOS_WDT_HZ * XOS_TOUT_LONG_MS / 1000);

  localparam logic [1:0] XOS_DIV8_LAST = 2'h3;

  // The fuse capture waits this many cycles so the synchronisers and the registered decode are both valid.
  localparam logic [2:0] XOS_SETTLE_LAST = 3'h4;

  typedef enum logic [1:0] {
    XOS_TOUT_NONE = 2'h0,
    XOS_TOUT_SHORT = 2'h1,
    XOS_TOUT_LONG = 2'h2
  } xos_tout_t;

  typedef struct packed {
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic divide_by_eight_fuse;
  } xos_fuses_t;

  typedef struct packed {
    logic [14:0] startup_cycles;
    xos_tout_t tout;
  } xos_timing_t;

  typedef enum logic [2:0] {
    XOS_ST_FUSE = 3'h0,
    XOS_ST_TOUT = 3'h1,
    XOS_ST_COUNT = 3'h3,
    XOS_ST_RUN = 3'h2,
    XOS_ST_SLEEP = 3'h6
  } xos_state_t;

endpackage

// ===== verilog/xos_startup_ctrl.sv
/*
 * Start-up controller for the low power crystal oscillator.
 * Catches the fuses after reset, times the watchdog time-out on a reset start,
 * counts oscillator cycles before releasing internal reset, and makes the
 * optional divide-by-eight system clock enable.
 * Assumes fuse pins, the wake request and the watchdog tick are asynchronous.
 */
`timescale 1ns/100ps
module xos_startup_ctrl
  import xos_pkg::*;
(
  input wire logic sys_clk_i, // Oscillator output clock.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire logic [3:0] clock_source_select_fuses_i, // Clock select fuses, 0 = programmed.
  input wire logic [1:0] startup_time_fuses_i, // Start-up time fuses.
  input wire logic divide_by_eight_fuse_i, // Divider fuse, 0 = programmed.
  input wire logic wdt_tick_i, // Watchdog oscillator clock level.
  input wire logic sleep_req_i, // High while in power-down or power-save.
  output logic internal_reset_o, // Held high until start-up completes.
  output logic [1:0] freq_range_o, // Range mode 0..3 for 0.4, 0.9, 3.0, 8.0 MHz.
  output logic range_valid_o, // Upper select bits name a low power crystal mode.
  output logic sys_clk_en_o, // System clock enable after the prescaler.
  output logic div8_active_o // Divide-by-eight in use.
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire logic [8:0] sync2_q;
  logic wdt_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_sync
      logic raw;
      logic stage1_q;
      logic stage2_q;
      if (gi < 4) begin : g_cs
        assign raw = clock_source_select_fuses_i[gi];
      end else if (gi < 6) begin : g_su
        assign raw = startup_time_fuses_i[gi - 4];
      end else if (gi == 6) begin : g_dv
        assign raw = divide_by_eight_fuse_i;
      end else if (gi == 7) begin : g_wd
        assign raw = wdt_tick_i;
      end else begin : g_sl
        assign raw = sleep_req_i;
      end
      // Each bit keeps its own flops so that no vector has more than one writing process.
      always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          stage1_q <= 1'h1;
          stage2_q <= 1'h1;
        end else begin
          stage1_q <= raw;
          stage2_q <= stage1_q;
        end
      end
      assign sync2_q[gi] = stage2_q;
    end
  endgenerate

  wire logic wdt_edge = sync2_q[7] & ~wdt_prev_q;
  wire logic sleeping = sync2_q[8];

  // ****************************************
  // Fuse image and decode
  // ****************************************
  xos_fuses_t fuses_q;
  xos_fuses_t fuses_d;
  xos_timing_t timing;

  xos_timing_decode xos_timing_decode_inst (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .fuses_i(fuses_q),
    .timing_o(timing)
  );

  // ****************************************
  // Start-up sequencer
  // ****************************************
  xos_state_t state_q;
  xos_state_t state_d;
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic [13:0] wdt_cnt_q;
  logic [13:0] wdt_cnt_d;
  logic [1:0] div_q;
  logic [1:0] div_d;
  logic rst_q;
  logic rst_d;
  logic en_q;
  logic en_d;
  logic [1:0] range_q;
  logic [1:0] range_d;
  logic valid_q;
  logic valid_d;
  logic div8_q;
  logic div8_d;
  logic [13:0] tout_len;
  logic [2:0] settle_q;
  logic [2:0] settle_d;

  always_comb begin
    tout_len = (timing.tout == XOS_TOUT_LONG) ? XOS_WDT_LONG : XOS_WDT_SHORT; // RULE_09
    state_d = state_q;
    cnt_d = cnt_q;
    wdt_cnt_d = wdt_cnt_q;
    fuses_d = fuses_q;
    rst_d = rst_q;
    range_d = range_q;
    valid_d = valid_q;
    div8_d = div8_q;
    settle_d = settle_q;
    case (state_q)
      XOS_ST_FUSE: begin
        // Four passes let the synchronisers, the fuse image and the registered decode settle before use.
        fuses_d = '{clock_source_select_fuses: sync2_q[3:0], startup_time_fuses: sync2_q[5:4],
                    divide_by_eight_fuse: sync2_q[6]}; // RULE_11
        settle_d = settle_q + 3'h1;
        if (settle_q == XOS_SETTLE_LAST) begin
          range_d = fuses_q.clock_source_select_fuses[2:1]; // RULE_01
          valid_d = fuses_q.clock_source_select_fuses[3]; // RULE_01
          div8_d = (fuses_q.divide_by_eight_fuse == XOS_FUSE_PROGRAMMED); // RULE_10
          wdt_cnt_d = '0;
          cnt_d = '0;
          state_d = (timing.tout == XOS_TOUT_NONE) ? XOS_ST_COUNT : XOS_ST_TOUT;
        end
      end
      XOS_ST_TOUT: begin
        if (wdt_edge) begin
          wdt_cnt_d = wdt_cnt_q + 14'h0001;
        end
        if (wdt_cnt_q >= tout_len) begin
          cnt_d = '0;
          state_d = XOS_ST_COUNT;
        end
      end
      XOS_ST_COUNT: begin
        // Reset starts add the fixed 19 cycles; wake-ups count only the start-up figure.
        cnt_d = cnt_q + 15'h0001; // RULE_08
        if (cnt_q + 15'h0001 >= timing.startup_cycles + (rst_q ? XOS_RST_EXTRA : 15'h0000)) begin
          rst_d = 1'h0; // RULE_08
          state_d = XOS_ST_RUN;
        end
      end
      XOS_ST_RUN: begin
        // Once running, the count register serves as the upper bit of the divider.
        if (div8_q && div_q == XOS_DIV8_LAST) begin
          cnt_d = cnt_q + 15'h0001; // RULE_05
        end
        if (sleeping) begin
          state_d = XOS_ST_SLEEP;
        end
      end
      XOS_ST_SLEEP: begin
        if (!sleeping) begin
          cnt_d = '0;
          state_d = XOS_ST_COUNT; // RULE_02
        end
      end
      default: begin
        state_d = XOS_ST_FUSE;
      end
    endcase
  end

  // Divide-by-eight runs as a one-in-eight clock enable so the block keeps one clock.
  always_comb begin
    div_d = div_q + 2'h1;
    en_d = 1'h0;
    if (state_q == XOS_ST_RUN) begin
      if (div8_q) begin
        en_d = (div_q == XOS_DIV8_LAST) & cnt_q[0]; // RULE_05
        div_d = div_q + 2'h1;
      end else begin
        en_d = 1'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= XOS_ST_FUSE;
      cnt_q <= '0;
      wdt_cnt_q <= '0;
      fuses_q <= '1;
      rst_q <= 1'h1;
      range_q <= 2'h0;
      valid_q <= 1'h0;
      div8_q <= 1'h0;
      settle_q <= 3'h0;
      wdt_prev_q <= 1'h1;
      div_q <= 2'h0;
      en_q <= 1'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wdt_cnt_q <= wdt_cnt_d;
      fuses_q <= fuses_d;
      rst_q <= rst_d;
      range_q <= range_d;
      valid_q <= valid_d;
      div8_q <= div8_d;
      settle_q <= settle_d;
      wdt_prev_q <= sync2_q[7];
      div_q <= div_d;
      en_q <= en_d;
    end
  end

  assign internal_reset_o = rst_q;
  assign freq_range_o = range_q;
  assign range_valid_o = valid_q;
  assign sys_clk_en_o = en_q;
  assign div8_active_o = div8_q;

endmodule

// ===== verilog/xos_timing_decode.sv
/*
 * Fuse decoder: turns the held fuse image into start-up count and time-out class.
 * Assumes the fuse image is stable; output comes from a register.
 */
`timescale 1ns/100ps
module xos_timing_decode
  import xos_pkg::*;
(
  input wire logic sys_clk_i, // Oscillator clock.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire xos_fuses_t fuses_i, // Held fuse image.
  output xos_timing_t timing_o // Registered timing choice.
);

  xos_timing_t timing_d;
  xos_timing_t timing_q;

  always_comb begin
    timing_d.startup_cycles = XOS_SU_16K;
    timing_d.tout = XOS_TOUT_NONE;
    case ({fuses_i.clock_source_select_fuses[0], fuses_i.startup_time_fuses})
      3'h0: begin
        timing_d.startup_cycles = XOS_SU_258; // RULE_02
        timing_d.tout = XOS_TOUT_SHORT;
      end
      3'h1: begin
        timing_d.startup_cycles = XOS_SU_258; // RULE_02
        timing_d.tout = XOS_TOUT_LONG;
      end
      3'h2: begin
        timing_d.startup_cycles = XOS_SU_1K; // RULE_03
        timing_d.tout = XOS_TOUT_NONE;
      end
      3'h3: begin
        timing_d.startup_cycles = XOS_SU_1K; // RULE_03
        timing_d.tout = XOS_TOUT_SHORT;
      end
      3'h4: begin
        timing_d.startup_cycles = XOS_SU_1K; // RULE_03
        timing_d.tout = XOS_TOUT_LONG;
      end
      3'h5: begin
        timing_d.startup_cycles = XOS_SU_16K; // RULE_04
        timing_d.tout = XOS_TOUT_NONE;
      end
      3'h6: begin
        timing_d.startup_cycles = XOS_SU_16K; // RULE_04
        timing_d.tout = XOS_TOUT_SHORT;
      end
      default: begin
        timing_d.startup_cycles = XOS_SU_16K; // RULE_04
        timing_d.tout = XOS_TOUT_LONG;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timing_q <= '{startup_cycles: XOS_SU_16K, tout: XOS_TOUT_LONG};
    end else begin
      timing_q <= timing_d;
    end
  end

  assign timing_o = timing_q;

endmodule
